/* File: core/fmr_read_seq.sv */
/*
  Multi-line fast read sequencer of a serial flash: dual/quad output,
  dual/quad address-data reads, continuous read mode and burst wrap.
  Assumes the array answers mem_rdata for mem_addr within one mclk,
  and that busy and quad enable come from status logic on mclk.
*/
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - opcode 3Bh: single-line address, data two bits per clock on lines 0-1.
// - dual output read has eight ignored dummy clocks after the address.
// - opcode 6Bh: data four bits per clock, same framing as 3Bh.
// - quad output read accepted only when quad enable is 1.
// - quad output read has eight ignored dummy clocks after the address.
// - opcode BBh: address taken two bits per clock on lines 0-1.
// - mode byte follows address of I/O reads; only its bits 5-4 matter.
// - mode select 10 lets the next dual I/O read skip its opcode.
// - any other mode select returns to full opcode on next access.
// - opcode EBh: address and mode four per clock, then four dummies.
// - quad I/O read honoured only with quad enable set.
// - mode select 10 lets the next quad I/O read skip its opcode.
// - with wrap on, quad I/O data wraps inside its aligned section.
// - wrap disable low enables wrap; length 8, 16, 32 or 64 bytes.
// - stored wrap setting applies to all later quad I/O reads.
// - wrap disable comes up as 1 after reset.
// - wrap command: opcode on one line, dummy and wrap bits four per clock; affects only quad I/O.
// - sample on rising serial edge, drive on falling edge, MSB first.
// - address increments after each output byte, streaming on.
// - reads while busy are ignored and leave the busy cycle alone.
module fmr_read_seq #(
  parameter int ADDR_W = 24
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_n,
  input wire logic quad_enable_bit,
  input wire logic busy_cycle_flag,
  input wire logic [7:0] mem_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic cont_mode,
  output logic [2:0] wrap_setting_bits
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // address must split evenly over 1, 2 and 4 lines and cover a page
  if (ADDR_W < 12 || ADDR_W > 32 || (ADDR_W % 4) != 0) begin : g_bad_addr
    $error("fmr_read_seq: ADDR_W must be a multiple of 4 from 12 to 32");
  end

  localparam int SW = ADDR_W;

  fmr_link_if lk ();

  fmr_pin_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .dq_pin(dq_in),
    .lk(lk)
  );

  fmr_pkg::fmr_state_t state_q, state_d;
  logic [7:0] cmd_q, cmd_d, cont_cmd_q, cont_cmd_d, byte_q, byte_d;
  logic [1:0] lane_q, lane_d, beat_q, beat_d;
  logic [5:0] cnt_q, cnt_d;
  logic [SW-1:0] shift_q, shift_d, addr_q, addr_d;
  logic cont_q, cont_d;
  logic [2:0] wrap_q, wrap_d;
  logic [3:0] dq_out_q, dq_out_d, oe_n_q, oe_n_d;

  // ----------------------------------------------------------------
  // command helpers
  // ----------------------------------------------------------------
  // input lanes per opcode
  function automatic logic [1:0] lane_of(input logic [7:0] op);
    logic [1:0] l;
    l = fmr_pkg::LANE_1;
    if (op == fmr_pkg::OP_DUAL_IO) l = fmr_pkg::LANE_2;
    if (op == fmr_pkg::OP_QUAD_IO || op == fmr_pkg::OP_SET_WRAP) l = fmr_pkg::LANE_4;
    return l;
  endfunction

  // clocks of the address (or wrap dummy) phase
  function automatic logic [5:0] addr_clks(input logic [7:0] op);
    logic [5:0] c;
    c = 6'(ADDR_W >> lane_of(op));
    if (op == fmr_pkg::OP_SET_WRAP) c = 6'(fmr_pkg::WRAP_DUMMY_BITS >> fmr_pkg::LANE_4);
    return c;
  endfunction

  // ----------------------------------------------------------------
  // decode of incoming bits and opcode
  // ----------------------------------------------------------------
  // lines shift in MSB first, the highest line in use holding the oldest bit of a beat
  wire [SW-1:0] shift_in = (lane_q == fmr_pkg::LANE_4) ? {shift_q[SW-5:0], lk.dq[3:0]} :
    (lane_q == fmr_pkg::LANE_2) ? {shift_q[SW-3:0], lk.dq[1:0]} :
    {shift_q[SW-2:0], lk.dq[0]};
  wire cnt_last = (cnt_q == 6'h01);
  wire [7:0] op_byte = shift_in[7:0];
  wire op_known = (op_byte == fmr_pkg::OP_DUAL_OUT) || (op_byte == fmr_pkg::OP_QUAD_OUT) ||
    (op_byte == fmr_pkg::OP_DUAL_IO) || (op_byte == fmr_pkg::OP_QUAD_IO) ||
    (op_byte == fmr_pkg::OP_SET_WRAP);
  wire op_quad = (op_byte == fmr_pkg::OP_QUAD_OUT) || (op_byte == fmr_pkg::OP_QUAD_IO);
  wire op_ok = op_known && !busy_cycle_flag && (!op_quad || quad_enable_bit);
  wire cmd_io = (cmd_q == fmr_pkg::OP_DUAL_IO) || (cmd_q == fmr_pkg::OP_QUAD_IO);
  wire cmd_out_dual = (cmd_q == fmr_pkg::OP_DUAL_OUT) || (cmd_q == fmr_pkg::OP_DUAL_IO);
  // resumed quad I/O also needs quad enable
  wire cont_resume = cont_q && (cont_cmd_q == fmr_pkg::OP_DUAL_IO || quad_enable_bit);
  wire [1:0] beat_last = cmd_out_dual ? 2'h3 : 2'h1;

  // ----------------------------------------------------------------
  // wrapped address step
  // ----------------------------------------------------------------
  // wrap only ever shapes the quad I/O read
  wire wrap_on = (cmd_q == fmr_pkg::OP_QUAD_IO) && !wrap_q[fmr_pkg::WRAP_DIS_POS];
  wire [7:0] wrap_mask = 8'((fmr_pkg::WRAP_MIN_BYTES << wrap_q[2:1]) - 8'h01);
  wire [SW-1:0] addr_inc = SW'(addr_q + 1'b1);
  // low bits wrap in the aligned section, upper bits hold
  wire [SW-1:0] addr_next = wrap_on ?
    {addr_q[SW-1:8], (addr_q[7:0] & ~wrap_mask) | (addr_inc[7:0] & wrap_mask)} : addr_inc;
  wire [7:0] out_src = (beat_q == 2'h0) ? mem_rdata : byte_q;

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    lane_d = lane_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    cont_d = cont_q;
    cont_cmd_d = cont_cmd_q;
    wrap_d = wrap_q;
    beat_d = beat_q;
    byte_d = byte_q;
    dq_out_d = dq_out_q;
    oe_n_d = oe_n_q;
    if (lk.cs_end) begin
      // frame end releases lines, continuous mode kept
      state_d = fmr_pkg::ST_IDLE;
      oe_n_d = fmr_pkg::OE_ALL_OFF;
      beat_d = 2'h0;
    end else begin
      case (state_q)
        fmr_pkg::ST_IDLE: begin
          if (lk.cs_start) begin
            beat_d = 2'h0;
            if (busy_cycle_flag) begin
              state_d = fmr_pkg::ST_IGNORE;
            end else if (cont_resume) begin
              // skip the opcode, start on the address
              state_d = fmr_pkg::ST_ADDR;
              cmd_d = cont_cmd_q;
              lane_d = lane_of(cont_cmd_q);
              cnt_d = addr_clks(cont_cmd_q);
            end else begin
              state_d = fmr_pkg::ST_OPCODE;
              lane_d = fmr_pkg::LANE_1;
              cnt_d = fmr_pkg::OPCODE_CLKS;
            end
          end
        end
        fmr_pkg::ST_OPCODE: begin
          if (lk.sclk_rise) begin
            shift_d = shift_in;
            cnt_d = cnt_q - 6'h01;
            if (cnt_last) begin
              cmd_d = op_byte;
              lane_d = lane_of(op_byte);
              cnt_d = addr_clks(op_byte);
              state_d = op_ok ? fmr_pkg::ST_ADDR : fmr_pkg::ST_IGNORE;
            end
          end
        end
        fmr_pkg::ST_ADDR: begin
          // address width per clock follows lane_q
          if (lk.sclk_rise) begin
            shift_d = shift_in;
            cnt_d = cnt_q - 6'h01;
            if (cnt_last) begin
              if (cmd_q == fmr_pkg::OP_SET_WRAP) begin
                state_d = fmr_pkg::ST_WRAP;
                cnt_d = 6'(fmr_pkg::WRAP_BITS >> fmr_pkg::LANE_4);
              end else if (cmd_io) begin
                addr_d = shift_in;
                state_d = fmr_pkg::ST_MODE;
                cnt_d = 6'(fmr_pkg::MODE_BITS >> lane_q);
              end else begin
                addr_d = shift_in;
                state_d = fmr_pkg::ST_DUMMY;
                cnt_d = fmr_pkg::DUMMY_OUT_CLKS;
              end
            end
          end
        end
        fmr_pkg::ST_MODE: begin
          if (lk.sclk_rise) begin
            shift_d = shift_in;
            cnt_d = cnt_q - 6'h01;
            if (cnt_last) begin
              // only the select bits of the upper nibble are kept
              cont_d = (shift_in[fmr_pkg::MODE_SEL_LSB +: 2] == fmr_pkg::CONT_SELECT);
              cont_cmd_d = cmd_q;
              // quad I/O waits four dummies, dual I/O none
              state_d = (cmd_q == fmr_pkg::OP_QUAD_IO) ? fmr_pkg::ST_DUMMY : fmr_pkg::ST_DATA;
              cnt_d = fmr_pkg::DUMMY_QIO_CLKS;
            end
          end
        end
        fmr_pkg::ST_DUMMY: begin
          // input lines ignored while dummies run
          if (lk.sclk_rise) begin
            cnt_d = cnt_q - 6'h01;
            if (cnt_last) begin
              state_d = fmr_pkg::ST_DATA;
            end
          end
        end
        fmr_pkg::ST_DATA: begin
          // lines turn round only at the first data falling edge
          if (lk.sclk_fall) begin
            // two or four bits a beat, upper bits on upper lines
            dq_out_d = cmd_out_dual ? {2'b00, out_src[7:6]} : out_src[7:4];
            byte_d = cmd_out_dual ? {out_src[5:0], 2'b00} : {out_src[3:0], 4'h0};
            // dual reads drive lines 0-1 only
            oe_n_d = cmd_out_dual ? fmr_pkg::OE_DUAL : fmr_pkg::OE_QUAD;
            beat_d = beat_q + 2'h1;
            if (beat_q == beat_last) begin
              // next byte address after the last beat
              beat_d = 2'h0;
              addr_d = addr_next;
            end
          end
        end
        fmr_pkg::ST_WRAP: begin
          if (lk.sclk_rise) begin
            shift_d = shift_in;
            cnt_d = cnt_q - 6'h01;
            if (cnt_last) begin
              // keep wrap length and disable bit, drop the rest
              wrap_d = shift_in[fmr_pkg::WRAP_FIELD_LSB +: 3];
              state_d = fmr_pkg::ST_IGNORE;
            end
          end
        end
        fmr_pkg::ST_IGNORE: begin
          state_d = fmr_pkg::ST_IGNORE;
        end
        default: begin
          state_d = fmr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // sequencer state; wrap setting survives every frame
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= fmr_pkg::ST_IDLE;
      cmd_q <= 8'h00;
      lane_q <= fmr_pkg::LANE_1;
      cnt_q <= 6'h00;
      cont_q <= 1'b0;
      cont_cmd_q <= 8'h00;
      wrap_q <= fmr_pkg::WRAP_RESET;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      lane_q <= lane_d;
      cnt_q <= cnt_d;
      cont_q <= cont_d;
      cont_cmd_q <= cont_cmd_d;
      wrap_q <= wrap_d;
    end
  end

  // data path and pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_q <= '0;
      addr_q <= '0;
      beat_q <= 2'h0;
      byte_q <= 8'h00;
      dq_out_q <= 4'h0;
      oe_n_q <= fmr_pkg::OE_ALL_OFF;
    end else begin
      shift_q <= shift_d;
      addr_q <= addr_d;
      beat_q <= beat_d;
      byte_q <= byte_d;
      dq_out_q <= dq_out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe_n = oe_n_q;
  assign mem_addr = addr_q;
  assign cont_mode = cont_q;
  assign wrap_setting_bits = wrap_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_frame_opens_resumed;
    lk.cs_start && cont_resume && !busy_cycle_flag;
  endsequence

  sequence s_wrap_last_bits;
    state_q == fmr_pkg::ST_WRAP && lk.sclk_rise && cnt_last && !lk.cs_end;
  endsequence

  chk_frame_end_release: assert property (
    lk.cs_end |=> (dq_oe_n == fmr_pkg::OE_ALL_OFF) && state_q == fmr_pkg::ST_IDLE)
    else $error("lines not released at frame end");

  chk_dual_upper_idle: assert property (
    (state_q == fmr_pkg::ST_DATA && cmd_out_dual) |-> dq_oe_n[3:2] == 2'b11)
    else $error("dual read drives upper lines");

  chk_quad_needs_enable: assert property (
    (state_q == fmr_pkg::ST_OPCODE && state_d == fmr_pkg::ST_ADDR && op_quad)
      |-> quad_enable_bit)
    else $error("quad read accepted without quad enable");

  chk_busy_ignores: assert property (
    (state_q == fmr_pkg::ST_IDLE && lk.cs_start && busy_cycle_flag)
      |=> state_q == fmr_pkg::ST_IGNORE ##1 dq_oe_n == fmr_pkg::OE_ALL_OFF)
    else $error("read taken while busy");

  chk_wrap_reset_off: assert property (
    $fell(reset) |-> wrap_setting_bits == fmr_pkg::WRAP_RESET)
    else $error("wrap not disabled after reset");

  chk_dummy_quiet: assert property (
    state_q == fmr_pkg::ST_DUMMY |-> dq_oe_n == fmr_pkg::OE_ALL_OFF)
    else $error("lines driven during dummy clocks");

  chk_resume_skips_op: assert property (
    s_frame_opens_resumed |=> state_q == fmr_pkg::ST_ADDR && cmd_q == $past(cont_cmd_q))
    else $error("continuous read did not skip opcode");

  chk_plain_increment: assert property (
    (state_q == fmr_pkg::ST_DATA && lk.sclk_fall && beat_q == beat_last && !wrap_on)
      |=> mem_addr == SW'($past(mem_addr) + 1'b1))
    else $error("address did not step by one");

  chk_wrap_section: assert property (
    (state_q == fmr_pkg::ST_DATA && lk.sclk_fall && beat_q == beat_last && wrap_on)
      |=> (mem_addr & ~SW'($past(wrap_mask))) == ($past(mem_addr) & ~SW'($past(wrap_mask))))
    else $error("wrapped address left its section");

  chk_wrap_stored: assert property (
    s_wrap_last_bits |=> wrap_setting_bits == $past(shift_in[fmr_pkg::WRAP_FIELD_LSB +: 3])
      ##1 wrap_setting_bits == $past(wrap_setting_bits))
    else $error("wrap setting not stored");

  chk_mode_select: assert property (
    (state_q == fmr_pkg::ST_MODE && lk.sclk_rise && cnt_last && !lk.cs_end)
      |=> cont_mode == ($past(shift_in[fmr_pkg::MODE_SEL_LSB +: 2]) == fmr_pkg::CONT_SELECT))
    else $error("continuous mode select mis-taken");

endmodule

`default_nettype wire

/* File: core/fmr_pkg.sv */
/*
  Constants shared by the multi-line fast read logic: opcodes, phase
  lengths, field positions, reset values and the sequencer state type.
  Assumes a byte-wide flash array outside the block, read by address.
*/
`default_nettype none

package fmr_pkg;

  // ----------------------------------------------------------------
  // opcodes taken on the single line
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;

  // ----------------------------------------------------------------
  // phase lengths, in serial clocks or bits
  // ----------------------------------------------------------------
  localparam logic [5:0] OPCODE_CLKS = 6'h08;
  localparam logic [5:0] DUMMY_OUT_CLKS = 6'h08;
  localparam logic [5:0] DUMMY_QIO_CLKS = 6'h04;
  localparam int MODE_BITS = 8;
  localparam int WRAP_DUMMY_BITS = 24;
  localparam int WRAP_BITS = 8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_SEL_LSB = 4;
  localparam logic [1:0] CONT_SELECT = 2'h2;
  localparam int WRAP_FIELD_LSB = 4;
  localparam int WRAP_DIS_POS = 0;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam logic [7:0] WRAP_MIN_BYTES = 8'h08;
  localparam logic [3:0] OE_ALL_OFF = 4'hf;
  localparam logic [3:0] OE_DUAL = 4'hc;
  localparam logic [3:0] OE_QUAD = 4'h0;

  // lanes per clock, as a shift count: 1, 2 or 4 lines
  localparam logic [1:0] LANE_1 = 2'h0;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_MODE = 3'b011,
    ST_DUMMY = 3'b100,
    ST_DATA = 3'b101,
    ST_WRAP = 3'b110,
    ST_IGNORE = 3'b111
  } fmr_state_t;

endpackage

`default_nettype wire

/* File: core/fmr_link_if.sv */
/*
  Synchronised view of the serial pins, passed from the pin sampler
  to the read sequencer. Assumes both ends run on mclk.
*/
`timescale 1ns/1ns
`default_nettype none

interface fmr_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_low;
  logic cs_start;
  logic cs_end;
  logic [3:0] dq;
  modport src(output sclk_rise, output sclk_fall, output cs_low, output cs_start,
    output cs_end, output dq);
  modport snk(input sclk_rise, input sclk_fall, input cs_low, input cs_start,
    input cs_end, input dq);
endinterface

`default_nettype wire

/* File: core/fmr_pin_sync.sv */
/*
  Pin sampler: two-flop synchronisers for chip select, serial clock and
  data lines, plus edge detection on the synchronised copies.
  Assumes mclk is several times faster than the serial clock.
*/
`timescale 1ns/1ns
`default_nettype none

module fmr_pin_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] dq_pin,
  fmr_link_if.src lk
);

  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic [3:0] dq_s1_q, dq_s2_q;

  // ----------------------------------------------------------------
  // synchronisers; first stages feed only the second stages
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dq_s1_q <= 4'h0;
      dq_s2_q <= 4'h0;
    end else begin
      cs_s1_q <= cs_n_pin;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ck_s1_q <= sclk_pin;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dq_s1_q <= dq_pin;
      dq_s2_q <= dq_s1_q;
    end
  end

  // edges from stage two against stage three; data is of the same age
  assign lk.sclk_rise = ck_s2_q & ~ck_s3_q;
  assign lk.sclk_fall = ~ck_s2_q & ck_s3_q;
  assign lk.cs_low = ~cs_s2_q;
  assign lk.cs_start = cs_s3_q & ~cs_s2_q;
  assign lk.cs_end = ~cs_s3_q & cs_s2_q;
  assign lk.dq = dq_s2_q;

endmodule

`default_nettype wire

/* File: tb/fmr_host_model.sv */
/*
  Host side of the serial link: chip select, serial clock and data
  lines, with read-back of what the flash drives on them.
  Assumes mclk runs far faster than the 125 ns serial clock.
*/
`timescale 1ns/1ns
`default_nettype none

module fmr_host_model (
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] dq_wire,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe_n,
  output logic drove
);
  logic [3:0] hval = 4'h0;
  logic [3:0] hen = 4'h0;
  logic tog = 1'b0;

  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  // released lines toggle, so a stale level never reads as data
  always @(posedge mclk) tog <= ~tog;
  // sticky flag: the flash drove a line inside this frame
  always @(posedge mclk) if (!cs_n && dq_oe_n !== 4'hf) drove <= 1'b1;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      dq_wire[k] = !dq_oe_n[k] ? dq_out[k] : (hen[k] ? hval[k] : tog ^ k[0]);
    end
  end
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drove = 1'b0;
  end

  // ----------------------------------------------------------------
  // bit level tasks, serial clock idles low
  // ----------------------------------------------------------------
  task automatic clk(input logic [3:0] o, input int w, output logic [3:0] i);
    hval = o;
    hen = 4'((1 << w) - 1);
    #62 sclk = 1'b1;
    i = dq_wire;
    // lines let go well before the fall
    #45 hen = 4'h0;
    #18 sclk = 1'b0;
  endtask

  // values go out msb first, w lines per clock
  task automatic put(input logic [31:0] v, input int n, input int w);
    logic [3:0] i;
    for (int k = n - 1; k >= 0; k--) clk(4'(v >> (k * w)), w, i);
  endtask

  task automatic get(input int n, input int w, output logic [7:0] r);
    logic [3:0] i;
    r = 8'h00;
    for (int k = 0; k < n; k++) begin
      clk(4'h0, 0, i);
      r = (r << w) | 8'(i & 4'((1 << w) - 1));
    end
  endtask

  // frames open off the sampling edge of mclk
  task automatic start();
    @(negedge mclk);
    drove = 1'b0;
    cs_n = 1'b0;
    #60;
  endtask

  task automatic stop();
    #40 cs_n = 1'b1;
    #100;
  endtask
endmodule

`default_nettype wire

/* File: tb/test_multi_io_fast_read_wrap.sv */
/*
  Self-checking bench for the multi-line fast read sequencer.
  Assumes the host model file is compiled first; the array is a
  combinational function of the address.
*/
`timescale 1ns/1ns
`default_nettype none

module test_multi_io_fast_read_wrap;
  logic mclk, reset, quad_enable_bit, busy_cycle_flag, cs_n, sclk, drove, cont_mode;
  logic [3:0] dq_wire, dq_out, dq_oe_n;
  logic [7:0] mem_rdata;
  logic [23:0] mem_addr;
  logic [2:0] wrap_setting_bits;
  int fails = 0;
  int n_tests = 0;
  int seed, a;

  // ----------------------------------------------------------------
  // array model and instances
  // ----------------------------------------------------------------
  function automatic logic [7:0] mem_val(input int x);
    return 8'(x ^ (x >> 8) ^ 8'h5a);
  endfunction
  assign mem_rdata = mem_val(int'(mem_addr));

  fmr_read_seq #(.ADDR_W(24)) fmr_read_seq_inst (.mclk(mclk), .reset(reset),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .dq_in(dq_wire), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .quad_enable_bit(quad_enable_bit),
    .busy_cycle_flag(busy_cycle_flag), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .cont_mode(cont_mode), .wrap_setting_bits(wrap_setting_bits));
  fmr_host_model fmr_host_model_inst (.mclk(mclk), .cs_n(cs_n), .sclk(sclk),
    .dq_wire(dq_wire), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .drove(drove));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // checking and frames
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // op 00 means no opcode (continuous mode); wsz 0 means linear
  task automatic frame(input logic [7:0] op, input int aw, input int mw,
      input logic [7:0] md, input int nd, input int dw, input int ad, input int n,
      input int wsz);
    logic [7:0] r;
    logic [7:0] exp_q[$];
    int e;
    // expected bytes from the step and wrap rules, queued in order
    for (int k = 0; k < n; k++) begin
      e = (wsz > 0) ? ((ad & ~(wsz - 1)) | ((ad + k) & (wsz - 1))) : ad + k;
      exp_q.push_back(mem_val(e));
    end
    fmr_host_model_inst.start();
    if (op != 8'h00) fmr_host_model_inst.put(32'(op), 8, 1);
    fmr_host_model_inst.put(32'(ad), 24 / aw, aw);
    if (mw > 0) fmr_host_model_inst.put(32'(md), 8 / mw, mw);
    repeat (nd) fmr_host_model_inst.put($urandom, 1, aw);
    for (int k = 0; k < n; k++) begin
      fmr_host_model_inst.get(8 / dw, dw, r);
      chk(r, exp_q.pop_front());
    end
    fmr_host_model_inst.stop();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    quad_enable_bit = 1'b0;
    busy_cycle_flag = 1'b0;
    seed = $urandom(29795);
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(8'(wrap_setting_bits), 8'h01);
    chk(8'(cont_mode), 8'h00);
    a = int'($urandom & 32'h00ffffff);
    frame(8'h3b, 1, 0, 8'h00, 8, 2, a, 3, 0);
    chk(8'(dq_oe_n), 8'h0f);
    // quad output refused while quad enable is low
    frame(8'h6b, 1, 0, 8'h00, 12, 4, a, 0, 0);
    chk(8'(drove), 8'h00);
    // an opcode this block does not know is ignored for the whole frame
    frame(8'h5c, 1, 0, 8'h00, 8, 2, a, 0, 0);
    chk(8'(drove), 8'h00);
    @(posedge mclk) quad_enable_bit <= 1'b1;
    frame(8'h6b, 1, 0, 8'h00, 8, 4, a + 5, 4, 0);
    @(posedge mclk) busy_cycle_flag <= 1'b1;
    frame(8'hbb, 2, 2, 8'h20, 4, 2, a, 0, 0);
    chk(8'(drove), 8'h00);
    chk(8'(cont_mode), 8'h00);
    @(posedge mclk) busy_cycle_flag <= 1'b0;
    frame(8'hbb, 2, 2, 8'h2c, 0, 2, a, 2, 0);
    chk(8'(cont_mode), 8'h01);
    frame(8'h00, 2, 2, 8'hff, 0, 2, a + 9, 2, 0);
    chk(8'(cont_mode), 8'h00);
    frame(8'heb, 4, 4, 8'ha5, 4, 4, a, 2, 0);
    chk(8'(cont_mode), 8'h01);
    frame(8'h00, 4, 4, 8'h20, 4, 4, a + 3, 2, 0);
    // ones on line zero for eight clocks leave continuous mode
    fmr_host_model_inst.start();
    fmr_host_model_inst.put(32'h000000ff, 8, 1);
    fmr_host_model_inst.stop();
    chk(8'(cont_mode), 8'h00);
    for (int l = 0; l < 4; l++) begin
      frame(8'h77, 4, 4, 8'(l << 5), 0, 4, int'($urandom), 0, 0);
      chk(8'(wrap_setting_bits), 8'(l << 1));
      frame(8'heb, 4, 4, 8'hff, 4, 4, a, (8 << l) + 3, 8 << l);
    end
    frame(8'h6b, 1, 0, 8'h00, 8, 4, a | 32'h3e, 4, 0);
    chk(8'(wrap_setting_bits), 8'h06);
    // a mid-run reset takes the enabled wrap back to off
    @(posedge mclk) reset <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(8'(wrap_setting_bits), 8'h01);
    frame(8'h77, 4, 4, 8'h70, 0, 4, 0, 0, 0);
    chk(8'(wrap_setting_bits), 8'h07);
    frame(8'heb, 4, 4, 8'hff, 4, 4, a | 32'h3e, 4, 0);
    print_verdict();
  end

  // about 820 serial clocks (some 107 us) are expected; this allows nearly five times that
  initial begin
    #500000;
    fails++;
    print_verdict();
  end
endmodule

`default_nettype wire
